/* File: core/rcw_pkg.sv */
// Shared constants for the real-time clock with wakeup timer.
// Assumes a 100 MHz pclk and a 32.768 kHz oscillator strobe.
package rcw_pkg;
   // Register indices; the byte address on APB is four times the index.
   localparam logic [5:0] A_SEC = 6'h10;
   localparam logic [5:0] A_MIN = 6'h11;
   localparam logic [5:0] A_HOUR = 6'h12;
   localparam logic [5:0] A_WEEK = 6'h13;
   localparam logic [5:0] A_DAY = 6'h14;
   localparam logic [5:0] A_MON = 6'h15;
   localparam logic [5:0] A_YEAR = 6'h16;
   localparam logic [5:0] A_PLO = 6'h1A;
   localparam logic [5:0] A_PHI = 6'h1B;
   localparam logic [5:0] A_FSC = 6'h1C;
   localparam logic [5:0] A_FLG = 6'h1D;
   localparam logic [5:0] A_CTL = 6'h1E;
   localparam logic [5:0] A_OFS = 6'h30;
   // Values after reset.
   localparam logic [7:0] R_ZERO = 8'h00;
   localparam logic [7:0] R_ONE = 8'h01;
   localparam logic [7:0] R_FSC = 8'h04;
   localparam logic [15:0] R_PRE = 16'h0001;
   // Field positions.
   localparam int B_TE = 4;
   localparam int B_TF = 4;
   localparam int B_TIE = 4;
   localparam int B_STOP = 6;
   localparam int B_COUNTDOWN_PAUSE = 2;
   localparam int B_TBKE = 0;
   localparam int B_DTE = 7;
   // Writable bits of the time and date counters.
   localparam logic [7:0] M_SEC = 8'h7F;
   localparam logic [7:0] M_HOUR = 8'h3F;
   localparam logic [7:0] M_DAY = 8'h3F;
   localparam logic [7:0] M_MON = 8'h1F;
   // Oscillator divider: 15 stages, stages from 256 Hz downward start at 6.
   localparam int DIV_W = 15;
   localparam int DIV_CLR_LSB = 6;
   // Interrupt release times, least values.
   localparam int CLK_NS = 10;
   localparam int REL_FAST_NS = 122000;
   localparam int REL_SLOW_NS = 7570000;
   localparam int REL_FAST_CYC = (REL_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int REL_SLOW_CYC = (REL_SLOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int REL_W = 20;
   // Countdown source codes.
   localparam logic [2:0] SRC_4096 = 3'h0;
   localparam logic [2:0] SRC_64 = 3'h1;
   localparam logic [2:0] SRC_SEC = 3'h2;
   localparam logic [2:0] SRC_MIN = 3'h3;
   localparam logic [2:0] SRC_HOUR = 3'h4;
   typedef enum logic [1:0] {IRQ_IDLE = 2'b01, IRQ_LOW = 2'b10} rcw_irq_e;
endpackage

/* File: core/rcw_link_if.sv */
// Signals between the register core, the oscillator divider and the
// wakeup timer. All signals are synchronous to pclk.
`timescale 1ns/1ps
interface rcw_link_if;
   logic osc_tick;
   logic clr_div;
   logic t4096;
   logic t64;
   logic t1;
   logic tmin;
   logic thour;
   logic stop;
   logic te;
   logic te_rise;
   logic pause;
   logic countdown_irq_gate;
   logic [2:0] tsel;
   logic [15:0] preset;
   logic evt;
   logic [15:0] count;
   logic irq_n;
   modport pre (input osc_tick, clr_div, output t4096, t64, t1);
   modport cal (output osc_tick, clr_div, tmin, thour, stop, te, te_rise,
      pause, countdown_irq_gate, tsel, preset, input t1, evt, count, irq_n);
   modport wkt (input t4096, t64, t1, tmin, thour, stop, te, te_rise,
      pause, countdown_irq_gate, tsel, preset, output evt, count, irq_n);
endinterface

/* File: core/rcw_prescaler.sv */
// Divider from the 32.768 kHz strobe to 4096 Hz, 64 Hz and 1 Hz ticks.
// Assumes osc_tick is a one-cycle strobe synchronous to pclk.
`timescale 1ns/1ps
module rcw_prescaler
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic clk_en, // Freezes all state while low.
   rcw_link_if.pre lk // Tick outputs and divider clear.
);
   typedef struct packed {
      logic [rcw_pkg::DIV_W-1:0] div;
   } rcw_pre_s;
   localparam logic [rcw_pkg::DIV_W-1:0] CLR_MASK =
      {(rcw_pkg::DIV_W - rcw_pkg::DIV_CLR_LSB){1'b1}} <<
      rcw_pkg::DIV_CLR_LSB;
   rcw_pre_s cur_ff;
   rcw_pre_s nxt_pre;
   always_comb
   begin
      nxt_pre = cur_ff;
      if (lk.clr_div)
         nxt_pre.div = (cur_ff.div & ~CLR_MASK) + {14'h0000, lk.osc_tick};
      else
         nxt_pre.div = cur_ff.div + {14'h0000, lk.osc_tick};
   end
   assign lk.t4096 = lk.osc_tick & (&cur_ff.div[2:0]);
   assign lk.t64 = lk.osc_tick & ~lk.clr_div & (&cur_ff.div[8:0]);
   assign lk.t1 = lk.osc_tick & ~lk.clr_div & (&cur_ff.div);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cur_ff <= '0;
      else if (clk_en)
         cur_ff <= nxt_pre;
   end
endmodule // rcw_prescaler

/* File: core/rcw_wakeup.sv */
// Wakeup countdown with periodic reload and self-releasing interrupt.
// Assumes the tick inputs are one-cycle strobes from the divider/core.
`timescale 1ns/1ps
module rcw_wakeup #(
   parameter int FAST_CYC = rcw_pkg::REL_FAST_CYC,
   parameter int SLOW_CYC = rcw_pkg::REL_SLOW_CYC
)
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic clk_en, // Freezes all state while low.
   rcw_link_if.wkt lk // Timer control and status.
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [rcw_pkg::REL_W-1:0] rel;
      rcw_pkg::rcw_irq_e st;
   } rcw_wkt_s;
   rcw_wkt_s cur_ff;
   rcw_wkt_s nxt_wkt;
   logic tick;
   logic evt;
   always_comb
   begin
      case (lk.tsel)
         rcw_pkg::SRC_4096: tick = lk.t4096;
         rcw_pkg::SRC_64: tick = lk.t64 & ~lk.stop;
         rcw_pkg::SRC_SEC: tick = lk.t1 & ~lk.stop;
         rcw_pkg::SRC_MIN: tick = lk.tmin & ~lk.stop;
         rcw_pkg::SRC_HOUR: tick = lk.thour & ~lk.stop;
         default: tick = 1'b0;
      endcase
   end
   always_comb
   begin
      nxt_wkt = cur_ff;
      evt = 1'b0;
      if (lk.te_rise)
         nxt_wkt.cnt = lk.preset;
      else if (lk.te && !lk.pause && tick)
      begin
         if (cur_ff.cnt <= 16'h0001)
         begin
            nxt_wkt.cnt = lk.preset;
            evt = 1'b1;
         end
         else
            nxt_wkt.cnt = cur_ff.cnt - 16'h0001;
      end
      unique case (cur_ff.st)
         rcw_pkg::IRQ_IDLE:
            if (evt && lk.countdown_irq_gate)
            begin
               nxt_wkt.st = rcw_pkg::IRQ_LOW;
               nxt_wkt.rel = (lk.tsel == rcw_pkg::SRC_4096) ?
                  FAST_CYC[rcw_pkg::REL_W-1:0] : SLOW_CYC[rcw_pkg::REL_W-1:0];
            end
         rcw_pkg::IRQ_LOW:
            if (!lk.countdown_irq_gate || cur_ff.rel <= 20'h00001)
               nxt_wkt.st = rcw_pkg::IRQ_IDLE;
            else
               nxt_wkt.rel = cur_ff.rel - 20'h00001;
      endcase
   end
   assign lk.evt = evt;
   assign lk.count = cur_ff.cnt;
   assign lk.irq_n = (cur_ff.st != rcw_pkg::IRQ_LOW);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur_ff.cnt <= rcw_pkg::R_PRE;
         cur_ff.rel <= '0;
         cur_ff.st <= rcw_pkg::IRQ_IDLE;
      end
      else if (clk_en)
         cur_ff <= nxt_wkt;
   end
endmodule // rcw_wakeup

/* File: core/rcw_rtc_top.sv */
// Register core of the real-time clock: time and calendar counters,
// wakeup timer registers and rate offset setting, reached over APB.
// Assumes osc_tick strobes once per 32.768 kHz period, synchronous to pclk.
//
// What this block does
// - An APB transfer freezes the counters; held seconds apply after it.
// - Seconds and minutes count BCD 00 to 59, carrying on rollover.
// - Writing seconds clears the 256 Hz to 1 Hz divider stages.
// - Hours count BCD 00 to 23, advanced by minutes carry.
// - Weekday one-hot rotates 01h to 40h and back on minutes carry.
// - Weekday gives no carry and ignores the date counters.
// - Day counts BCD 28 to 31 days by month and leap year.
// - Month counts BCD 1 to 12 on the day carry.
// - Year counts BCD 00 to 99 and sets February length.
// - Every year divisible by four, 00 included, is leap.
// - Wakeup timer gives periodic events and can be paused.
// - The wakeup interrupt output releases itself after a set time.
// - Sixteen-bit preset at 1Ah low and 1Bh high, 0001h to FFFFh.
// - Counter reads give preset when disabled, live count when enabled.
// - Source select picks 4096, 64, 1, 1/60, 1/3600 Hz; release times.
// - The first countdown period may be shortened.
// - Enabling restarts from preset; disabling leaves the interrupt alone.
// - Event flag latches until written zero; writing one is ignored.
// - Interrupt gate enables assertion; clearing it releases the output.
// - Offset register holds an enable bit and a seven-bit value.
`timescale 1ns/1ps
module rcw_rtc_top #(
   parameter int REL_FAST_CYC = rcw_pkg::REL_FAST_CYC,
   parameter int REL_SLOW_CYC = rcw_pkg::REL_SLOW_CYC
)
(
   input wire logic pclk, // System clock, 100 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic clk_en, // Freezes all state while low.
   input wire logic osc_tick, // One strobe per 32.768 kHz period.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped addresses.
   output logic irq_n, // Wakeup interrupt, active low.
   output logic offset_correction_on, // Rate correction enable.
   output logic [6:0] offset_value_bits // Rate correction value.
);
   generate
      if (REL_FAST_CYC < 1 || REL_FAST_CYC >= (1 << rcw_pkg::REL_W) ||
          REL_SLOW_CYC < 1 || REL_SLOW_CYC >= (1 << rcw_pkg::REL_W))
      begin : g_bad_param
         $error("Release counts must lie between 1 and 2**20 - 1.");
      end
   endgenerate

   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] week;
      logic [7:0] day;
      logic [7:0] mon;
      logic [7:0] year;
      logic [7:0] plo;
      logic [7:0] phi;
      logic [7:0] fsc;
      logic [7:0] ctl;
      logic [7:0] ofs;
      logic tf;
      logic [1:0] pend;
      logic te_rise;
      logic tmin;
      logic thour;
      logic [31:0] prdata;
      logic slverr;
   } rcw_top_s;

   localparam rcw_top_s RST = '{
      sec: rcw_pkg::R_ZERO, min: rcw_pkg::R_ZERO, hour: rcw_pkg::R_ZERO,
      week: rcw_pkg::R_ONE, day: rcw_pkg::R_ONE, mon: rcw_pkg::R_ONE,
      year: rcw_pkg::R_ZERO, plo: rcw_pkg::R_PRE[7:0],
      phi: rcw_pkg::R_PRE[15:8], fsc: rcw_pkg::R_FSC,
      ctl: rcw_pkg::R_ZERO, ofs: rcw_pkg::R_ZERO, tf: 1'b0, pend: 2'h0,
      te_rise: 1'b0, tmin: 1'b0, thour: 1'b0, prdata: 32'h00000000,
      slverr: 1'b0};

   rcw_top_s cur_ff;
   rcw_top_s nxt_top;
   rcw_link_if lk ();

   // True for every index that holds a register.
   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx >= rcw_pkg::A_SEC && idx <= rcw_pkg::A_YEAR) ||
         (idx >= rcw_pkg::A_PLO && idx <= rcw_pkg::A_CTL) ||
         idx == rcw_pkg::A_OFS;
   endfunction

   // One BCD step; 99 wraps to 00.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] != 4'h9)
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      else if (v[7:4] != 4'h9)
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
         bcd_inc = 8'h00;
   endfunction

   // A BCD year is a multiple of four when an even tens digit meets 0, 4
   // or 8, or an odd tens digit meets 2 or 6. Century years are not
   // special here; software has to patch them.
   function automatic logic is_leap(input logic [7:0] y);
      if (y[4])
         is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
         is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
            (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] last_day(input logic [7:0] m,
      input logic [7:0] y);
      case (m)
         8'h02: last_day = is_leap(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
         default: last_day = 8'h31;
      endcase
   endfunction

   logic [5:0] idx;
   logic acc;
   logic wr;
   logic adv;
   logic c_min;
   logic c_hour;
   logic c_day;
   logic c_mon;
   logic c_year;
   logic [7:0] rd;

   assign idx = paddr[7:2];
   assign acc = psel & penable & clk_en;
   assign wr = acc & pwrite & is_mapped(idx);
   // While a transfer is open the counters stand still; seconds that
   // arrive meanwhile are queued and applied one per cycle afterwards.
   assign adv = !psel && !cur_ff.ctl[rcw_pkg::B_STOP] &&
      (cur_ff.pend != 2'h0 || lk.t1);
   assign c_min = adv && cur_ff.sec == 8'h59;
   assign c_hour = c_min && cur_ff.min == 8'h59;
   assign c_day = c_hour && cur_ff.hour == 8'h23;
   assign c_mon = c_day && cur_ff.day == last_day(cur_ff.mon, cur_ff.year);
   assign c_year = c_mon && cur_ff.mon == 8'h12;

   // Read data is captured in the setup phase so that it comes from a
   // flop; the live count may therefore be one cycle old.
   always_comb
   begin
      rd = 8'h00;
      case (idx)
         rcw_pkg::A_SEC: rd = cur_ff.sec;
         rcw_pkg::A_MIN: rd = cur_ff.min;
         rcw_pkg::A_HOUR: rd = cur_ff.hour;
         rcw_pkg::A_WEEK: rd = cur_ff.week;
         rcw_pkg::A_DAY: rd = cur_ff.day;
         rcw_pkg::A_MON: rd = cur_ff.mon;
         rcw_pkg::A_YEAR: rd = cur_ff.year;
         rcw_pkg::A_PLO:
            rd = cur_ff.fsc[rcw_pkg::B_TE] ? lk.count[7:0] : cur_ff.plo;
         rcw_pkg::A_PHI:
            rd = cur_ff.fsc[rcw_pkg::B_TE] ? lk.count[15:8] : cur_ff.phi;
         rcw_pkg::A_FSC: rd = cur_ff.fsc;
         rcw_pkg::A_FLG: rd = {3'h0, cur_ff.tf, 4'h0};
         rcw_pkg::A_CTL: rd = cur_ff.ctl;
         rcw_pkg::A_OFS: rd = cur_ff.ofs;
         default: rd = 8'h00;
      endcase
   end

   always_comb
   begin
      nxt_top = cur_ff;
      nxt_top.te_rise = 1'b0;
      nxt_top.tmin = 1'b0;
      nxt_top.thour = 1'b0;
      if (adv)
      begin
         nxt_top.sec = c_min ? 8'h00 : bcd_inc(cur_ff.sec);
         if (c_min)
            nxt_top.min = c_hour ? 8'h00 : bcd_inc(cur_ff.min);
         if (c_hour)
         begin
            nxt_top.hour = c_day ? 8'h00 : bcd_inc(cur_ff.hour);
            // Only a rotation; nothing flows out of the weekday.
            nxt_top.week = {1'b0, cur_ff.week[5:0], cur_ff.week[6]};
         end
         if (c_day)
            nxt_top.day = c_mon ? 8'h01 : bcd_inc(cur_ff.day);
         if (c_mon)
            nxt_top.mon = c_year ? 8'h01 : bcd_inc(cur_ff.mon);
         if (c_year)
            nxt_top.year = bcd_inc(cur_ff.year);
         nxt_top.tmin = c_min;
         nxt_top.thour = c_hour;
      end
      // Queue depth saturates at three seconds.
      if (psel)
      begin
         if (lk.t1 && cur_ff.pend != 2'h3)
            nxt_top.pend = cur_ff.pend + 2'h1;
      end
      else if (adv && !lk.t1 && cur_ff.pend != 2'h0)
         nxt_top.pend = cur_ff.pend - 2'h1;
      if (psel && !penable)
      begin
         nxt_top.prdata = {24'h000000, rd};
         nxt_top.slverr = !is_mapped(idx);
      end
      if (wr)
      begin
         case (idx)
            rcw_pkg::A_SEC:
            begin
               nxt_top.sec = pwdata[7:0] & rcw_pkg::M_SEC;
               nxt_top.pend = 2'h0;
            end
            rcw_pkg::A_MIN: nxt_top.min = pwdata[7:0] & rcw_pkg::M_SEC;
            rcw_pkg::A_HOUR: nxt_top.hour = pwdata[7:0] & rcw_pkg::M_HOUR;
            rcw_pkg::A_WEEK: nxt_top.week = {1'b0, pwdata[6:0]};
            rcw_pkg::A_DAY: nxt_top.day = pwdata[7:0] & rcw_pkg::M_DAY;
            rcw_pkg::A_MON: nxt_top.mon = pwdata[7:0] & rcw_pkg::M_MON;
            rcw_pkg::A_YEAR: nxt_top.year = pwdata[7:0];
            rcw_pkg::A_PLO: nxt_top.plo = pwdata[7:0];
            rcw_pkg::A_PHI: nxt_top.phi = pwdata[7:0];
            rcw_pkg::A_FSC:
            begin
               nxt_top.fsc = pwdata[7:0];
               nxt_top.te_rise = pwdata[rcw_pkg::B_TE] &
                  ~cur_ff.fsc[rcw_pkg::B_TE];
            end
            rcw_pkg::A_CTL: nxt_top.ctl = pwdata[7:0];
            rcw_pkg::A_OFS: nxt_top.ofs = pwdata[7:0];
            default: nxt_top.ofs = cur_ff.ofs;
         endcase
      end
      // A timer event in the clearing cycle keeps the flag set.
      nxt_top.tf = (cur_ff.tf & ~(wr && idx == rcw_pkg::A_FLG &&
         !pwdata[rcw_pkg::B_TF])) | lk.evt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cur_ff <= RST;
      else if (clk_en)
         cur_ff <= nxt_top;
   end

   assign lk.osc_tick = osc_tick;
   assign lk.clr_div = wr && idx == rcw_pkg::A_SEC;
   assign lk.tmin = cur_ff.tmin;
   assign lk.thour = cur_ff.thour;
   assign lk.stop = cur_ff.ctl[rcw_pkg::B_STOP];
   assign lk.te = cur_ff.fsc[rcw_pkg::B_TE];
   assign lk.te_rise = cur_ff.te_rise;
   // The backup-mode select makes the pause bit ineffective.
   assign lk.pause = cur_ff.ctl[rcw_pkg::B_COUNTDOWN_PAUSE] &
      ~cur_ff.ctl[rcw_pkg::B_TBKE];
   assign lk.countdown_irq_gate = cur_ff.ctl[rcw_pkg::B_TIE];
   assign lk.tsel = cur_ff.fsc[2:0];
   assign lk.preset = {cur_ff.phi, cur_ff.plo};

   rcw_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .lk(lk)
   );

   rcw_wakeup #(
      .FAST_CYC(REL_FAST_CYC),
      .SLOW_CYC(REL_SLOW_CYC)
   ) u_wkt (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .lk(lk)
   );

   assign prdata = cur_ff.prdata;
   assign pready = acc;
   assign pslverr = cur_ff.slverr & acc;
   assign irq_n = lk.irq_n;
   assign offset_correction_on = cur_ff.ofs[rcw_pkg::B_DTE];
   assign offset_value_bits = cur_ff.ofs[6:0];
endmodule // rcw_rtc_top

/* File: verif/rcw_rtc_chk.sv */
// Port-level assertions for the real-time clock register core.
// Assumes a single pclk domain and the zero-wait APB answer.
`timescale 1ns/1ps
module rcw_rtc_chk #(
   parameter int REL_FAST_CYC = 5,
   parameter int REL_SLOW_CYC = 20
)
(
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic clk_en, // Clock enable.
   input wire logic osc_tick, // Oscillator strobe.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB address.
   input wire logic [31:0] pwdata, // APB write data.
   input wire logic [31:0] prdata, // APB read data.
   input wire logic pready, // APB ready.
   input wire logic pslverr, // APB error.
   input wire logic irq_n, // Interrupt, active low.
   input wire logic offset_correction_on, // Offset enable.
   input wire logic [6:0] offset_value_bits // Offset value.
);
   logic [19:0] low_cnt_ff;
   logic mapped;
   logic ofs_wr;
   assign mapped = paddr[7:2] inside {[6'h10:6'h16], [6'h1A:6'h1E], 6'h30};
   assign ofs_wr = pready && pwrite && paddr[7:2] == 6'h30;
   // Length of the present low phase of the interrupt output.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_cnt_ff <= 20'h00000;
      else if (irq_n)
         low_cnt_ff <= 20'h00000;
      else
         low_cnt_ff <= low_cnt_ff + 20'h00001;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready;
      pready == (psel && penable && clk_en);
   endproperty
   a_ready: assert property (p_ready) else $error("pready wrong");
   property p_hi;
      prdata[31:8] == 24'h000000;
   endproperty
   a_hi: assert property (p_hi) else $error("prdata upper bits set");
   property p_err;
      pready |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_hold;
      $changed(prdata) |-> $past(psel && !penable);
   endproperty
   a_hold: assert property (p_hold) else $error("prdata moved");
   property p_ofs_wr;
      ofs_wr |=> {offset_correction_on, offset_value_bits} == $past(pwdata[7:0]);
   endproperty
   a_ofs_wr: assert property (p_ofs_wr) else $error("offset not written");
   property p_ofs_keep;
      $changed({offset_correction_on, offset_value_bits}) |-> $past(ofs_wr);
   endproperty
   a_ofs_keep: assert property (p_ofs_keep) else $error("offset moved");
   property p_rel;
      low_cnt_ff <= REL_SLOW_CYC;
   endproperty
   a_rel: assert property (p_rel) else $error("irq_n held too long");
   property p_freeze;
      !clk_en |=> $stable(irq_n);
   endproperty
   a_freeze: assert property (p_freeze) else $error("irq_n moved frozen");
   c_irq: cover property ($fell(irq_n));
   c_err: cover property (pready && pslverr);
   c_ofs: cover property (ofs_wr);
endmodule // rcw_rtc_chk

bind rcw_rtc_top rcw_rtc_chk #(
   .REL_FAST_CYC(REL_FAST_CYC),
   .REL_SLOW_CYC(REL_SLOW_CYC)
) chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .osc_tick(osc_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_n(irq_n),
   .offset_correction_on(offset_correction_on),
   .offset_value_bits(offset_value_bits));

/* File: verif/rcw_host_model.sv */
// Host controller model: APB master for the register core.
// Assumes the bench calls xfer one transfer at a time.
`timescale 1ns/1ps
module rcw_host_model
(
   input wire logic pclk, // Clock.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Error.
   output logic psel, // Select.
   output logic penable, // Enable.
   output logic pwrite, // Direction.
   output logic [7:0] paddr, // Byte address.
   output logic [31:0] pwdata // Write data.
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // The request stands until pready is seen high; a stall simply waits.
   task automatic xfer(input logic w, input logic [5:0] idx,
      input logic [7:0] d, output logic [7:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // rcw_host_model

/* File: verif/rtc_calendar_wakeup_timer_test.sv */
// Self-checking bench for the real-time clock register core.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module rtc_calendar_wakeup_timer_test;
   typedef struct {logic [5:0] idx; logic [7:0] wr; logic [7:0] rd;
      logic err;} rcw_row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic osc_tick = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq_n, offset_correction_on;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] offset_value_bits;
   logic [7:0] q;
   logic e;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   rcw_row_s rows [12] = '{
      '{rcw_pkg::A_SEC, 8'h45, 8'h45, 1'b0},
      '{rcw_pkg::A_MIN, 8'h39, 8'h39, 1'b0},
      '{rcw_pkg::A_HOUR, 8'h17, 8'h17, 1'b0},
      '{rcw_pkg::A_WEEK, 8'h01, 8'h01, 1'b0},
      '{rcw_pkg::A_DAY, 8'h29, 8'h29, 1'b0},
      '{rcw_pkg::A_MON, 8'h02, 8'h02, 1'b0},
      '{rcw_pkg::A_YEAR, 8'h88, 8'h88, 1'b0},
      '{rcw_pkg::A_PLO, 8'h34, 8'h34, 1'b0},
      '{rcw_pkg::A_PHI, 8'h12, 8'h12, 1'b0},
      '{rcw_pkg::A_OFS, 8'h85, 8'h85, 1'b0},
      '{rcw_pkg::A_FLG, 8'h10, 8'h00, 1'b0},
      '{6'h1F, 8'h5A, 8'h00, 1'b1}};
   // February 28th of leap year 00, one second before midnight.
   rcw_row_s cal [7] = '{
      '{rcw_pkg::A_YEAR, 8'h00, 8'h00, 1'b0},
      '{rcw_pkg::A_MON, 8'h02, 8'h02, 1'b0},
      '{rcw_pkg::A_DAY, 8'h28, 8'h29, 1'b0},
      '{rcw_pkg::A_WEEK, 8'h40, 8'h01, 1'b0},
      '{rcw_pkg::A_HOUR, 8'h23, 8'h00, 1'b0},
      '{rcw_pkg::A_MIN, 8'h59, 8'h00, 1'b0},
      '{rcw_pkg::A_SEC, 8'h59, 8'h00, 1'b0}};
   rcw_rtc_top #(.REL_FAST_CYC(5), .REL_SLOW_CYC(20)) dut_u (.pclk(pclk),
      .presetn(presetn), .clk_en(clk_en), .osc_tick(osc_tick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_n(irq_n),
      .offset_correction_on(offset_correction_on),
      .offset_value_bits(offset_value_bits));
   rcw_host_model host_u (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   always #5 pclk = ~pclk;
   // The oscillator strobe runs fast so that one second takes 65536 cycles.
   always @(posedge pclk)
      osc_tick <= ~osc_tick;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_mismatch++;
         results();
      end
   end
   task chk8(input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: want %h got %h", $time, exp, got);
      end
   endtask
   task chk1(input logic exp, input logic got);
      chk8({7'h00, exp}, {7'h00, got});
   endtask
   task wr(input logic [5:0] i, input logic [7:0] d);
      host_u.xfer(1'b1, i, d, q, e);
   endtask
   task rd(input logic [5:0] i);
      host_u.xfer(1'b0, i, 8'h00, q, e);
   endtask
   task wait_irq(input logic lvl);
      n = 0;
      while (irq_n !== lvl && n < 400)
      begin
         n++;
         @(posedge pclk);
      end
   endtask
   task results;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[k])
      begin
         wr(rows[k].idx, rows[k].wr);
         chk1(rows[k].err, e);
         rd(rows[k].idx);
         chk8(rows[k].rd, q);
         chk1(rows[k].err, e);
      end
      chk8(8'h85, {offset_correction_on, offset_value_bits});
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(rcw_pkg::A_WEEK);
      chk8(8'h01, q);
      rd(rcw_pkg::A_FSC);
      chk8(8'h04, q);
      chk8(8'h00, {offset_correction_on, offset_value_bits});
      foreach (cal[k])
         wr(cal[k].idx, cal[k].wr);
      repeat (100) @(posedge pclk);
      clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b1;
      repeat (65500) @(posedge pclk);
      foreach (cal[k])
      begin
         rd(cal[k].idx);
         chk8(cal[k].rd, q);
      end
      wr(rcw_pkg::A_FSC, 8'h00);
      wr(rcw_pkg::A_PLO, 8'h03);
      wr(rcw_pkg::A_PHI, 8'h00);
      rd(rcw_pkg::A_PLO);
      chk8(8'h03, q);
      wr(rcw_pkg::A_CTL, 8'h10);
      wr(rcw_pkg::A_FSC, 8'h10);
      wait_irq(1'b0);
      chk1(1'b0, irq_n);
      chk1(1'b1, n >= 20 && n <= 60);
      rd(rcw_pkg::A_FLG);
      chk8(8'h10, q);
      wait_irq(1'b1);
      chk1(1'b1, irq_n);
      wr(rcw_pkg::A_FSC, 8'h00);
      wr(rcw_pkg::A_FLG, 8'h10);
      rd(rcw_pkg::A_FLG);
      chk8(8'h10, q);
      wr(rcw_pkg::A_FLG, 8'h00);
      rd(rcw_pkg::A_FLG);
      chk8(8'h00, q);
      wr(rcw_pkg::A_CTL, 8'h00);
      wr(rcw_pkg::A_FSC, 8'h10);
      repeat (100) @(posedge pclk);
      chk1(1'b1, irq_n);
      rd(rcw_pkg::A_FLG);
      chk8(8'h10, q);
      // The live count is not held during a read, so take two that agree.
      do
      begin
         rd(rcw_pkg::A_PLO);
         n = int'(q);
         rd(rcw_pkg::A_PLO);
      end
      while (int'(q) != n);
      chk1(1'b1, q >= 8'h01 && q <= 8'h03);
      results();
   end
endmodule // rtc_calendar_wakeup_timer_test
